// [tc_source.sv]
// Purpose: telecommand source for the data handling side
// Assumes: tasks are called at rising edges
// Notes:   load spacing scaled from seconds to GAP cycles
`timescale 1ns/1ps
`default_nettype none
module tc_source
    import upload_seq_pkg::*;
#(
    parameter int GAP = 20
) (
    // clock and flow control
    input  wire logic   clk_i,
    input  wire logic   ready_i,
    // header and words
    output logic        hv_o,
    output logic [7:0]  svc_o,
    output logic [7:0]  sub_o,
    output logic [7:0]  len_o,
    output logic        ok_o,
    output logic        wv_o,
    output logic [15:0] w_o,
    output logic        last_o
);
    initial {hv_o, svc_o, sub_o, len_o, ok_o, wv_o, w_o, last_o} = '0;
    // kind 0 plain init, 1 upload init (a = count), 2 load (a = address)
    function automatic logic [15:0] fw(input logic [1:0] k, input logic [31:0] a, input int i);
        if (k == 2'h2)
            return i == 0 ? a[31:16] : i == 1 ? a[15:0] : i < 4 ? 16'h0 : {a[13:6], 8'(i - 4)};
        return i == 0 ? VALIDATION_TAG : i % 8 == 1 ? a[15:0] : i == 8 && k[0] ? UPLOAD_TAG : 16'h0;
    endfunction
    task automatic send(input logic [7:0] s, t, l, input logic ok, input logic [31:0] a,
                        input logic [1:0] k);
        {hv_o, svc_o, sub_o, len_o, ok_o} <= {1'b1, s, t, l, ok};
        @(posedge clk_i);
        {hv_o, svc_o, sub_o, len_o, ok_o} <= {1'b0, ~s, ~t, ~l, ~ok};
        for (int i = 0; i < int'(l); i++)
        begin
            {wv_o, w_o, last_o} <= {1'b1, fw(k, a, i), i == int'(l) - 1};
            do @(posedge clk_i); while (!ready_i);
        end
        {wv_o, w_o, last_o} <= {1'b0, ~w_o, 1'b0};
        repeat (GAP) @(posedge clk_i);
    endtask
endmodule
`default_nettype wire

// [upload_seq_pkg.sv]
// Purpose: constants and types shared by the upload sequencer, its checker, tc_source and the bench
// Assumes: 50 MHz clock; telecommand words arrive as 16-bit words, high word first
// Notes:   event codes and service numbers are the block's fixed protocol values
`default_nettype none
package upload_seq_pkg;
    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam longint unsigned CLK_HZ            = 50_000_000;
    localparam longint unsigned BOOT_WINDOW_S     = 60;
    localparam longint unsigned BOOT_WINDOW_CYCLES = BOOT_WINDOW_S * CLK_HZ;

    // ----------------------------------------------------------------
    // events and services
    // ----------------------------------------------------------------
    localparam logic [15:0] EVT_STATE_CHANGE = 16'hA412;
    localparam logic [15:0] EVT_END_INIT     = 16'hA411;
    localparam logic [15:0] EVT_UPLOAD_OK    = 16'hA413;
    localparam logic [15:0] EVT_UPLOAD_FAIL  = 16'hA4F1;
    localparam logic [7:0]  SVC_MEMORY       = 8'h06;
    localparam logic [7:0]  SUB_LOAD         = 8'h02;
    localparam logic [7:0]  SUB_DUMP         = 8'h05;
    localparam logic [7:0]  SVC_PRIVATE      = 8'hD3;
    localparam logic [7:0]  SUB_INIT         = 8'h01;

    // ----------------------------------------------------------------
    // packet layout
    // ----------------------------------------------------------------
    localparam logic [7:0]  LOAD_WORDS     = 8'h70;
    localparam logic [7:0]  LOAD_LAST      = 8'h6F;
    localparam logic [7:0]  ADDR_LOW_IDX   = 8'h01;
    localparam logic [7:0]  ADDR_LAST      = 8'h03;
    localparam logic [7:0]  INIT_LAST      = 8'h09;
    localparam logic [7:0]  INIT_TAG4_IDX  = 8'h08;
    localparam logic [5:0]  DATA_WORDS32   = 6'h36;
    localparam logic [15:0] VALIDATION_TAG = 16'h3B00;
    localparam logic [15:0] UPLOAD_TAG     = 16'h1B00;
    localparam logic [31:0] LOAD_BASE      = 32'h0200_0000;
    localparam logic [31:0] LOAD_STEP      = 32'h0000_0040;

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    localparam int unsigned RAM_AW     = 22;
    localparam int unsigned FIFO_W     = 32;
    localparam int unsigned FIFO_DEPTH = 8;
    localparam logic [3:0]  FIFO_ROOM  = 4'h6;

    typedef logic [RAM_AW-1:0] ram_addr_t;

    typedef enum logic [3:0] {
        ST_BOOT, ST_MAIN, ST_END_INIT, ST_UPLOAD, ST_FLUSH,
        ST_READ, ST_WAIT, ST_CAP, ST_WRITE, ST_DONE
    } seq_state_t;

    typedef enum logic [2:0] {
        PK_IDLE, PK_INIT, PK_ADDR, PK_DATA, PK_SKIP
    } pkt_phase_t;
endpackage
`default_nettype wire

// [upload_sequencer.sv]
// Purpose: boot window, init telecommand evaluation and memory-load upload sequencer
// Assumes: packet reception and integrity checks are done upstream on the same clock
// Notes:   buffered image sits in an external RAM; commit copies it word by word to NVM
`timescale 1ns/1ps
`default_nettype none
module upload_sequencer
    import upload_seq_pkg::*;
#(
    parameter logic [31:0] BOOT_CYCLES = 32'(BOOT_WINDOW_CYCLES)
) (
    // clock, reset, enable
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    input  wire logic        ce_i,
    // telecommand header, one pulse per packet
    input  wire logic        hdr_valid_i,
    input  wire logic [7:0]  hdr_service_i,
    input  wire logic [7:0]  hdr_subtype_i,
    input  wire logic [7:0]  hdr_len_i,
    input  wire logic        hdr_ok_i,
    // telecommand data words
    input  wire logic        word_valid_i,
    output logic             word_ready_o,
    input  wire logic [15:0] word_i,
    input  wire logic        word_last_i,
    // acknowledgement and events
    output logic             ack_valid_o,
    output logic             ack_ok_o,
    output logic             evt_valid_o,
    output logic [15:0]      evt_id_o,
    output logic             dump_req_o,
    // program control
    output logic             main_run_o,
    output logic             upload_state_o,
    // buffer RAM
    output logic             ram_we_o,
    output logic             ram_re_o,
    input  wire logic        ram_ready_i,
    output logic [RAM_AW-1:0] ram_addr_o,
    output logic [31:0]      ram_wdata_o,
    input  wire logic [31:0] ram_rdata_i,
    // nonvolatile memory write port
    output logic             nvm_we_o,
    input  wire logic        nvm_ready_i,
    output logic [RAM_AW-1:0] nvm_addr_o,
    output logic [31:0]      nvm_data_o
);
    typedef struct packed {
        seq_state_t  state;
        pkt_phase_t  phase;
        logic [31:0] timer;
        logic [7:0]  idx;
        logic [15:0] hi;
        logic        tag0_ok;
        logic        tag4_ok;
        logic [15:0] cnt_tmp;
        logic        stored_upload;
        logic [15:0] stored_count;
        logic [15:0] load_count;
        logic [15:0] loads_done;
        logic [31:0] expected_addr;
        logic        broken;
        ram_addr_t   wptr;
        ram_addr_t   rptr;
        ram_addr_t   total;
        logic        ram_we;
        logic        ram_re;
        ram_addr_t   ram_addr;
        logic [31:0] ram_wdata;
        logic        nvm_we;
        ram_addr_t   nvm_addr;
        logic [31:0] nvm_data;
        logic        ack_valid;
        logic        ack_ok;
        logic        evt_valid;
        logic [15:0] evt_id;
        logic        dump_req;
        logic        main_run;
        logic        upload;
        logic        word_ready;
    } seq_t;

    seq_t        seq_reg;
    seq_t        seq_next;
    logic        fifo_in_valid;
    logic        fifo_in_ready;
    logic [31:0] fifo_in_data;
    logic        fifo_out_valid;
    logic        fifo_out_ready;
    logic [31:0] fifo_out_data;
    logic [3:0]  fifo_level;
    logic        word_fire;
    logic        hdr_take;
    logic        is_load;

    assign word_fire = word_valid_i && seq_reg.word_ready;
    assign hdr_take  = hdr_valid_i && (seq_reg.phase == PK_IDLE)
                       && (seq_reg.state != ST_MAIN);
    assign is_load   = (hdr_service_i == SVC_MEMORY) && (hdr_subtype_i == SUB_LOAD);

    // ----------------------------------------------------------------
    // payload buffer
    // ----------------------------------------------------------------
    // ready is registered, so it keeps two slots spare for the push in flight
    word_fifo #(
        .W (FIFO_W),
        .D (FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (clk_i),
        .srst_i      (srst_i),
        .ce_i        (ce_i),
        .in_valid_i  (fifo_in_valid),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (fifo_in_data),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (fifo_out_ready),
        .out_data_o  (fifo_out_data),
        .level_o     (fifo_level)
    );

    assign fifo_in_valid  = word_fire && (seq_reg.phase == PK_DATA) && seq_reg.idx[0];
    assign fifo_in_data   = {seq_reg.hi, word_i};
    assign fifo_out_ready = (!seq_reg.ram_we || ram_ready_i) && (seq_reg.state == ST_UPLOAD
                            || seq_reg.state == ST_FLUSH);

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always_comb
    begin
        seq_next           = seq_reg;
        seq_next.ack_valid = 1'b0;
        seq_next.evt_valid = 1'b0;
        seq_next.dump_req  = 1'b0;
        seq_next.ram_re    = 1'b0;
        seq_next.word_ready = (fifo_level <= FIFO_ROOM);

        // header handling: boot accepts all, upload filters services
        if (hdr_take)
        begin
            seq_next.idx       = '0;
            seq_next.ack_valid = 1'b1;
            seq_next.ack_ok    = 1'b1;
            seq_next.phase     = PK_SKIP;
            if (seq_reg.state == ST_BOOT)
            begin
                if (hdr_ok_i && hdr_service_i == SVC_PRIVATE && hdr_subtype_i == SUB_INIT)
                begin
                    seq_next.phase = PK_INIT;
                end
            end
            else if (hdr_service_i == SVC_PRIVATE)
            begin
                seq_next.ack_ok = 1'b0;
            end
            else if (is_load)
            begin
                if (hdr_ok_i && hdr_len_i == LOAD_WORDS && seq_reg.state == ST_UPLOAD
                    && seq_reg.loads_done != seq_reg.load_count)
                begin
                    seq_next.phase = PK_ADDR;
                end
                else
                begin
                    seq_next.ack_ok = 1'b0;
                end
            end
            else if (hdr_service_i == SVC_MEMORY && hdr_subtype_i == SUB_DUMP)
            begin
                seq_next.dump_req = 1'b1;
            end
            if (word_last_i && seq_next.phase == PK_SKIP)
            begin
                seq_next.phase = PK_SKIP;
            end
        end

        // word handling
        if (word_fire && seq_reg.phase != PK_IDLE)
        begin
            seq_next.idx = seq_reg.idx + 8'h01;
            unique case (seq_reg.phase)
                PK_INIT:
                begin
                    if (seq_reg.idx == '0)
                    begin
                        seq_next.tag0_ok = (word_i == VALIDATION_TAG);
                    end
                    if (seq_reg.idx == INIT_TAG4_IDX)
                    begin
                        seq_next.tag4_ok = (word_i == UPLOAD_TAG);
                    end
                    if (seq_reg.idx == INIT_LAST && word_last_i)
                    begin
                        seq_next.stored_upload = seq_reg.tag0_ok && seq_reg.tag4_ok;
                        seq_next.stored_count  = word_i;
                    end
                end
                PK_ADDR:
                begin
                    if (seq_reg.idx == '0)
                    begin
                        seq_next.hi = word_i;
                    end
                    if (seq_reg.idx == ADDR_LOW_IDX)
                    begin
                        if ({seq_reg.hi, word_i} == seq_reg.expected_addr)
                        begin
                            seq_next.expected_addr = seq_reg.expected_addr + LOAD_STEP;
                        end
                        else
                        begin
                            seq_next.evt_valid = 1'b1;
                            seq_next.evt_id    = EVT_UPLOAD_FAIL;
                            seq_next.broken    = 1'b1;
                            seq_next.phase     = PK_SKIP;
                        end
                    end
                    if (seq_reg.idx == ADDR_LAST)
                    begin
                        seq_next.phase = PK_DATA;
                    end
                end
                PK_DATA:
                begin
                    if (!seq_reg.idx[0])
                    begin
                        seq_next.hi = word_i;
                    end
                    if (seq_reg.idx == LOAD_LAST)
                    begin
                        seq_next.loads_done = seq_reg.loads_done + 16'h0001;
                        seq_next.phase      = word_last_i ? PK_IDLE : PK_SKIP;
                        if (seq_next.loads_done == seq_reg.load_count && !seq_reg.broken)
                        begin
                            seq_next.state = ST_FLUSH;
                        end
                    end
                end
                default:
                begin
                end
            endcase
            // a packet cut short inside a load breaks the image
            if (word_last_i)
            begin
                if ((seq_reg.phase == PK_ADDR || seq_reg.phase == PK_DATA)
                    && seq_reg.idx != LOAD_LAST && seq_next.phase != PK_SKIP)
                begin
                    seq_next.evt_valid = 1'b1;
                    seq_next.evt_id    = EVT_UPLOAD_FAIL;
                    seq_next.broken    = 1'b1;
                end
                seq_next.phase = PK_IDLE;
            end
        end

        // RAM write port drains the buffer
        if (fifo_out_ready)
        begin
            seq_next.ram_we = fifo_out_valid;
            if (fifo_out_valid)
            begin
                seq_next.ram_addr  = seq_reg.wptr;
                seq_next.ram_wdata = fifo_out_data;
                seq_next.wptr      = seq_reg.wptr + 1'b1;
            end
        end

        unique case (seq_reg.state)
            ST_BOOT:
            begin
                seq_next.timer = seq_reg.timer + 32'h0000_0001;
                if (seq_reg.timer == BOOT_CYCLES - 32'h0000_0001)
                begin
                    seq_next.evt_valid = 1'b1;
                    seq_next.evt_id    = EVT_STATE_CHANGE;
                    seq_next.phase     = PK_IDLE;
                    if (seq_reg.stored_upload)
                    begin
                        seq_next.state      = ST_END_INIT;
                        seq_next.load_count = seq_reg.stored_count;
                    end
                    else
                    begin
                        seq_next.state    = ST_MAIN;
                        seq_next.main_run = 1'b1;
                    end
                end
            end
            ST_MAIN:
            begin
                seq_next.word_ready = 1'b1;
            end
            ST_END_INIT:
            begin
                seq_next.evt_valid     = 1'b1;
                seq_next.evt_id        = EVT_END_INIT;
                seq_next.upload        = 1'b1;
                seq_next.expected_addr = LOAD_BASE;
                seq_next.state         = ST_UPLOAD;
            end
            ST_UPLOAD:
            begin
            end
            ST_FLUSH:
            begin
                if (!fifo_out_valid && !seq_reg.ram_we)
                begin
                    seq_next.total = ram_addr_t'(seq_reg.load_count) * ram_addr_t'(DATA_WORDS32);
                    seq_next.rptr  = '0;
                    seq_next.state = ST_READ;
                end
            end
            ST_READ:
            begin
                seq_next.ram_re   = 1'b1;
                seq_next.ram_addr = seq_reg.rptr;
                seq_next.state    = ST_WAIT;
            end
            ST_WAIT:
            begin
                seq_next.state = ST_CAP;
            end
            ST_CAP:
            begin
                seq_next.nvm_we   = 1'b1;
                seq_next.nvm_addr = seq_reg.rptr;
                seq_next.nvm_data = ram_rdata_i;
                seq_next.state    = ST_WRITE;
            end
            ST_WRITE:
            begin
                if (nvm_ready_i)
                begin
                    seq_next.nvm_we = 1'b0;
                    seq_next.rptr   = seq_reg.rptr + 1'b1;
                    if (seq_reg.rptr == seq_reg.total - 1'b1)
                    begin
                        seq_next.evt_valid = 1'b1;
                        seq_next.evt_id    = EVT_UPLOAD_OK;
                        seq_next.state     = ST_DONE;
                    end
                    else
                    begin
                        seq_next.state = ST_READ;
                    end
                end
            end
            ST_DONE:
            begin
            end
        endcase
        // no exit back to normal running once uploading
        if (seq_reg.upload)
        begin
            seq_next.upload   = 1'b1;
            seq_next.main_run = 1'b0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            seq_reg       <= '0;
            seq_reg.state <= ST_BOOT;
            seq_reg.phase <= PK_IDLE;
        end
        else if (ce_i)
        begin
            seq_reg <= seq_next;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign word_ready_o   = seq_reg.word_ready;
    assign ack_valid_o    = seq_reg.ack_valid;
    assign ack_ok_o       = seq_reg.ack_ok;
    assign evt_valid_o    = seq_reg.evt_valid;
    assign evt_id_o       = seq_reg.evt_id;
    assign dump_req_o     = seq_reg.dump_req;
    assign main_run_o     = seq_reg.main_run;
    assign upload_state_o = seq_reg.upload;
    assign ram_we_o       = seq_reg.ram_we;
    assign ram_re_o       = seq_reg.ram_re;
    assign ram_addr_o     = seq_reg.ram_addr;
    assign ram_wdata_o    = seq_reg.ram_wdata;
    assign nvm_we_o       = seq_reg.nvm_we;
    assign nvm_addr_o     = seq_reg.nvm_addr;
    assign nvm_data_o     = seq_reg.nvm_data;
endmodule
`default_nettype wire

// [upload_sequencer_assertions.sv]
// Purpose: port checks for upload_sequencer
// Assumes: ce_i high throughout
// Notes:   age_reg counts edges since reset release and stops at BOOT_CYCLES + 1
`timescale 1ns/1ps
`default_nettype none
module upload_sequencer_checker
    import upload_seq_pkg::*;
#(
    parameter logic [31:0] BOOT_CYCLES = 32'h32
) (
    // clock, reset, header
    input wire logic        clk_i,
    input wire logic        srst_i,
    input wire logic [7:0]  hdr_service_i,
    input wire logic        hdr_ok_i,
    // answers
    input wire logic        ack_valid_o,
    input wire logic        ack_ok_o,
    input wire logic        evt_valid_o,
    input wire logic [15:0] evt_id_o,
    input wire logic        main_run_o,
    input wire logic        upload_state_o,
    input wire logic        nvm_we_o,
    input wire logic        nvm_ready_i
);
    logic [31:0] age_reg;
    always_ff @(posedge clk_i)
        age_reg <= srst_i ? 32'h0 : age_reg + 32'(age_reg <= BOOT_CYCLES);
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    AST_BOOT_HOLD: assert property (age_reg < BOOT_CYCLES |-> !main_run_o && !upload_state_o)
        else $error("boot left early");
    AST_BOOT_EVT: assert property (evt_valid_o && evt_id_o == EVT_STATE_CHANGE |-> age_reg == BOOT_CYCLES)
        else $error("state event off time");
    AST_END_INIT: assert property ($rose(upload_state_o) |-> evt_valid_o && evt_id_o == EVT_END_INIT
        && $past(evt_id_o) == EVT_STATE_CHANGE) else $error("end of init event");
    AST_STAY: assert property (upload_state_o |=> upload_state_o)
        else $error("upload state left");
    AST_ONE_WAY: assert property (upload_state_o |-> !main_run_o)
        else $error("both branches taken");
    AST_PRIV: assert property (ack_valid_o && upload_state_o && $past(hdr_service_i) == SVC_PRIVATE
        |-> !ack_ok_o) else $error("private acked ok");
    AST_BAD_LOAD: assert property (ack_valid_o && upload_state_o && !$past(hdr_ok_i)
        && $past(hdr_service_i) == SVC_MEMORY |-> !ack_ok_o) else $error("bad load acked ok");
    AST_OK_EVT: assert property (evt_valid_o && evt_id_o == EVT_UPLOAD_OK
        |-> $past(nvm_we_o) && $past(nvm_ready_i)) else $error("success event early");
endmodule
bind upload_sequencer upload_sequencer_checker #(.BOOT_CYCLES(BOOT_CYCLES)) u_chk (.*);
`default_nettype wire

// [upload_sequencer_tb_top.sv]
// Purpose: self-checking bench for upload_sequencer
// Assumes: ce_i tied high
// Notes:   boot window shortened to 100 cycles
`timescale 1ns/1ps
`default_nettype none
module upload_sequencer_tb_top;
    import upload_seq_pkg::*;
    localparam logic [31:0] BOOT = 32'h64;
    logic clk_i = 1'b0, srst_i = 1'b1, ce_i = 1'b1, stall = 1'b0, ram_ready_i = 1'b1;
    logic hdr_valid_i, hdr_ok_i, word_valid_i, word_ready_o, word_last_i, nvm_ready_i = 1'b0;
    logic ack_valid_o, ack_ok_o, evt_valid_o, dump_req_o, main_run_o, upload_state_o;
    logic ram_we_o, ram_re_o, nvm_we_o;
    logic [7:0] hdr_service_i, hdr_subtype_i, hdr_len_i;
    logic [15:0] word_i, evt_id_o, ackv, nref, nw, ndump;
    logic [21:0] ram_addr_o, nvm_addr_o;
    logic [31:0] ram_wdata_o, nvm_data_o, ram_rdata_i = 32'h0, ram [0:127];
    logic [47:0] evh;
    int n_tests = 0, n_mismatch = 0;
    always #10 clk_i = ~clk_i;
    upload_sequencer #(.BOOT_CYCLES(BOOT)) dut (.*);
    tc_source src (.clk_i, .ready_i(word_ready_o), .hv_o(hdr_valid_i), .svc_o(hdr_service_i),
        .sub_o(hdr_subtype_i), .len_o(hdr_len_i), .ok_o(hdr_ok_i), .wv_o(word_valid_i),
        .w_o(word_i), .last_o(word_last_i));
    task automatic check(input logic [47:0] seen, exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("FAIL t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    // buffer RAM with one cycle read latency, slow NVM, event and ack logs
    always @(posedge clk_i)
    begin
        if (ram_we_o && ram_ready_i) ram[ram_addr_o[6:0]] <= ram_wdata_o;
        ram_rdata_i <= ram_re_o ? ram[ram_addr_o[6:0]] : ~ram_rdata_i;
        ram_ready_i <= !stall;
        nvm_ready_i <= !nvm_ready_i;
        if (ack_valid_o) ackv <= {ackv[14:0], ack_ok_o};
        if (evt_valid_o) evh <= {evh[31:0], evt_id_o};
        // cleared here under reset; power_up also clears them at the release edge
        nref <= srst_i ? 16'h0 : nref + 16'(word_valid_i && !word_ready_o);
        ndump <= srst_i ? 16'h0 : ndump + 16'(dump_req_o);
        if (nvm_we_o && nvm_ready_i)
        begin
            check(48'(nvm_addr_o), 48'(nw));
            check(48'(nvm_data_o), {16'h0, 8'(nw / 54), 8'(nw % 54 * 2), 8'(nw / 54), 8'(nw % 54 * 2 + 1)});
            nw <= nw + 16'h1;
        end
    end
    task automatic power_up(input logic up);
        srst_i <= 1'b1;
        repeat (20) @(posedge clk_i);
        {ackv, evh, nref, nw, ndump} <= '0;
        srst_i <= 1'b0;
        src.send(SVC_PRIVATE, SUB_INIT, 8'h0A, 1'b1, 32'h2, {1'b0, !up});
        src.send(SVC_PRIVATE, SUB_INIT, 8'h0A, 1'b1, 32'h2, {1'b0, up});
        repeat (BOOT) @(posedge clk_i);
        check(48'({main_run_o, upload_state_o}), up ? 48'h1 : 48'h2);
    endtask
    task automatic t_main();
        power_up(1'b0);
        check(evh, 48'(EVT_STATE_CHANGE));
        check(48'(ackv), 48'h3);
    endtask
    // two-load image; bad_addr breaks the address chain on the second load
    task automatic t_upload(input logic bad_addr);
        power_up(1'b1);
        src.send(SVC_PRIVATE, 8'h02, 8'h02, 1'b1, 32'h0, 2'h0);
        src.send(SVC_MEMORY, SUB_DUMP, 8'h02, 1'b1, 32'h0, 2'h0);
        src.send(SVC_MEMORY, SUB_LOAD, LOAD_WORDS, 1'b0, LOAD_BASE, 2'h2);
        stall <= 1'b1;
        fork
            src.send(SVC_MEMORY, SUB_LOAD, LOAD_WORDS, 1'b1, LOAD_BASE, 2'h2);
            begin repeat (60) @(posedge clk_i); stall <= 1'b0; end
        join
        src.send(SVC_MEMORY, SUB_LOAD, LOAD_WORDS, 1'b1, LOAD_BASE + (bad_addr ? 32'h80 : LOAD_STEP), 2'h2);
        for (int i = 0; i < 3000 && nw < 16'd108; i++) @(posedge clk_i);
        repeat (4) @(posedge clk_i);
        check(48'(ackv[6:0]), 48'h6B);
        check(48'({ndump, 15'h0, nref != 0}), 48'h10001);
        check(48'(nw), bad_addr ? 48'h0 : 48'd108);
        check(evh, {EVT_STATE_CHANGE, EVT_END_INIT, bad_addr ? EVT_UPLOAD_FAIL : EVT_UPLOAD_OK});
        check(48'(upload_state_o), 48'h1);
    endtask
    task automatic conclude();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        t_main();
        t_upload(1'b0);
        t_upload(1'b1);
        conclude();
    end
    // about two and a half times the expected run length
    initial
    begin
        repeat (12000) @(posedge clk_i);
        n_mismatch++;
        conclude();
    end
endmodule
`default_nettype wire

// [word_fifo.sv]
// Purpose: small flip-flop FIFO between the load parser and the RAM write port
// Assumes: single clock, synchronous reset, clock enable freezes everything
// Notes:   level_o lets the producer throttle itself one cycle ahead
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
    parameter int unsigned W = 32,
    parameter int unsigned D = 8
) (
    // clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 srst_i,
    input  wire logic                 ce_i,
    // fill side
    input  wire logic                 in_valid_i,
    output logic                      in_ready_o,
    input  wire logic [W-1:0]         in_data_i,
    // drain side
    output logic                      out_valid_o,
    input  wire logic                 out_ready_i,
    output logic [W-1:0]              out_data_o,
    // fill level
    output logic [$clog2(D+1)-1:0]    level_o
);
    localparam int unsigned AW = $clog2(D);
    localparam int unsigned LW = $clog2(D+1);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       wr;
        logic [AW-1:0]       rd;
        logic [LW-1:0]       level;
    } fifo_state_t;

    fifo_state_t st_reg;
    fifo_state_t st_next;
    logic        push;
    logic        pop;

    assign in_ready_o  = (st_reg.level != LW'(D));
    assign out_valid_o = (st_reg.level != '0);
    assign out_data_o  = st_reg.mem[st_reg.rd];
    assign level_o     = st_reg.level;
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_comb
    begin
        st_next = st_reg;
        if (push)
        begin
            st_next.mem[st_reg.wr] = in_data_i;
            st_next.wr = (st_reg.wr == AW'(D-1)) ? '0 : st_reg.wr + 1'b1;
        end
        if (pop)
        begin
            st_next.rd = (st_reg.rd == AW'(D-1)) ? '0 : st_reg.rd + 1'b1;
        end
        if (push && !pop)
        begin
            st_next.level = st_reg.level + 1'b1;
        end
        else if (pop && !push)
        begin
            st_next.level = st_reg.level - 1'b1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            st_reg <= '0;
        end
        else if (ce_i)
        begin
            st_reg <= st_next;
        end
    end
endmodule
`default_nettype wire
